// File: tll_defs.vh
/*
 * Constants of the three-wire latch loader: word layout, latch codes,
 * control latch fields, monitor selections and sampling figures.
 * Assumes it is included by bare name from the loader design files.
 */
`ifndef TLL_DEFS_VH
`define TLL_DEFS_VH

// ****************************************************************
// Word layout
// ****************************************************************
`define TLL_WORD_BITS 24
`define TLL_SEL_HI 1
`define TLL_SEL_LO 0
`define TLL_BITCNT_W 5

// ****************************************************************
// Latch selection codes
// ****************************************************************
`define TLL_SEL_CONTROL 2'h0
`define TLL_SEL_REF 2'h1
`define TLL_SEL_FEEDBACK 2'h2
`define TLL_SEL_TEST 2'h3

// ****************************************************************
// Control latch fields and reset values
// ****************************************************************
`define TLL_CTL_CORE_PD_BIT 20
`define TLL_CTL_CP_TRI_BIT 21
`define TLL_CTL_MON_LSB 5
`define TLL_CTL_MON_MSB 7
`define TLL_LATCH_RESET 24'h000000

// ****************************************************************
// Monitor selections
// ****************************************************************
`define TLL_MON_LOW 3'h0
`define TLL_MON_LOCK 3'h1
`define TLL_MON_RF 3'h2
`define TLL_MON_REF 3'h3

// ****************************************************************
// Timing
// ****************************************************************
`define TLL_CLK_PERIOD_NS 4
`define TLL_SYNC_STAGES 2

`endif

// File: tll_host.sv
/* Host model driving the three-wire serial port.
   Assumes calls start on a bench clock falling edge. */
`timescale 1ns/1ns
module tll_host (
    output logic sclk_out,
    output logic sdata_out,
    output logic strobe_out
);
initial begin
    sclk_out = 0;
    sdata_out = 0;
    strobe_out = 0;
end
// Serial clock stands low between words; data never idles on the last bit
task automatic send(input logic [23:0] w, input int n);
    int i;
    for (i = n - 1; i >= 0; i--) begin
        sdata_out = w[i];
        #40 sclk_out = 1;
        #40 sclk_out = 0;
    end
    sdata_out = ~w[0];
    #40 strobe_out = 1;
    #40 strobe_out = 0;
endtask
endmodule

// File: tll_props.sv
/* Checker of tll_top port behaviour.
   Assumes a bind to tll_top and one clock domain on REF_CLK_IN. */
`timescale 1ns/1ns
module tll_props #(
    parameter WORD_BITS = 24
) (
    input wire REF_CLK_IN,
    input wire RST_IN,
    input wire CHIP_ENABLE_IN,
    input wire LOCK_DETECT_IN,
    input wire RF_SCALED_IN,
    input wire REF_SCALED_IN,
    input wire MONITOR_OUTPUT_OUT,
    input wire CHARGE_PUMP_OUTPUT_OE_OUT,
    input wire CORE_POWERED_OUT,
    input wire [WORD_BITS-1:0] CONTROL_LATCH_OUT,
    input wire [WORD_BITS-1:0] REF_LATCH_OUT,
    input wire [WORD_BITS-1:0] FEEDBACK_LATCH_OUT,
    input wire FEEDBACK_UPDATE_OUT,
    input wire SHORT_WORD_OUT
);
wire [2:0] sel = CONTROL_LATCH_OUT[7:5];
wire mon_src = (sel == 3'h1) ? LOCK_DETECT_IN : (sel == 3'h2) ? RF_SCALED_IN : (sel == 3'h3) ? REF_SCALED_IN : 1'b0;
default clocking @(posedge REF_CLK_IN); endclocking
default disable iff (RST_IN);
// Windows allow for the two-flop synchronisers on the pins
chk_ce_tristate: assert property (!CHIP_ENABLE_IN [*4] |-> !CHARGE_PUMP_OUTPUT_OE_OUT)
    else $error("pump pin driven while disabled");
chk_ce_core_off: assert property (!CHIP_ENABLE_IN [*4] |-> !CORE_POWERED_OUT)
    else $error("core powered while disabled");
chk_pd_bit: assert property (CONTROL_LATCH_OUT[20] |=> !CORE_POWERED_OUT)
    else $error("core powered against power-down bit");
chk_cp_tri: assert property (CONTROL_LATCH_OUT[21] |=> !CHARGE_PUMP_OUTPUT_OE_OUT)
    else $error("pump pin driven against three-state bit");
chk_power_up: assert property ((CHIP_ENABLE_IN && !CONTROL_LATCH_OUT[20]) [*5] |-> CORE_POWERED_OUT)
    else $error("core not powered");
chk_fb_pulse: assert property (FEEDBACK_UPDATE_OUT |-> FEEDBACK_LATCH_OUT[1:0] == 2'h2 ##1 !FEEDBACK_UPDATE_OUT)
    else $error("bad feedback update pulse");
chk_ctl_sel: assert property ($changed(CONTROL_LATCH_OUT) |-> CONTROL_LATCH_OUT[1:0] == 2'h0)
    else $error("control latch loaded with wrong code");
chk_ref_sel: assert property ($changed(REF_LATCH_OUT) |-> REF_LATCH_OUT[1:0] == 2'h1)
    else $error("reference latch loaded with wrong code");
chk_mon_follow: assert property ((CORE_POWERED_OUT && $stable(mon_src)) [*5] |-> MONITOR_OUTPUT_OUT == mon_src)
    else $error("monitor does not show selected source");
chk_mon_off: assert property (!CORE_POWERED_OUT [*3] |-> !MONITOR_OUTPUT_OUT)
    else $error("monitor active while powered down");
cover property (FEEDBACK_UPDATE_OUT);
cover property ($rose(SHORT_WORD_OUT));
cover property (CORE_POWERED_OUT && sel == 3'h3);
cover property (CORE_POWERED_OUT && CONTROL_LATCH_OUT[21]);
endmodule
bind tll_top tll_props #(.WORD_BITS(WORD_BITS)) u_props (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
    .CHIP_ENABLE_IN(CHIP_ENABLE_IN), .LOCK_DETECT_IN(LOCK_DETECT_IN), .RF_SCALED_IN(RF_SCALED_IN),
    .REF_SCALED_IN(REF_SCALED_IN), .MONITOR_OUTPUT_OUT(MONITOR_OUTPUT_OUT),
    .CHARGE_PUMP_OUTPUT_OE_OUT(CHARGE_PUMP_OUTPUT_OE_OUT), .CORE_POWERED_OUT(CORE_POWERED_OUT),
    .CONTROL_LATCH_OUT(CONTROL_LATCH_OUT), .REF_LATCH_OUT(REF_LATCH_OUT),
    .FEEDBACK_LATCH_OUT(FEEDBACK_LATCH_OUT), .FEEDBACK_UPDATE_OUT(FEEDBACK_UPDATE_OUT),
    .SHORT_WORD_OUT(SHORT_WORD_OUT));

// File: tll_sync.v
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes every bit comes from outside the reference clock domain.
 */
`timescale 1ns/1ns
module tll_sync #(
    parameter WIDTH = 1
) (
    input wire clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ****************************************************************
    // Stages
    // ****************************************************************
    // The first stage is read by the second stage only
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: tll_tb_top.sv
/* Self-checking bench of tll_top against a bit-level model.
   Assumes tll_host drives the serial pins and tll_props is bound. */
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tll_tb_top;
logic clk = 0, rst = 1, ce = 0, lock = 0, rf = 0, refs = 0, pump = 0;
wire sclk, sdata, strobe, mon, cp, cp_oe, core, fbu, shortw;
wire [23:0] ctl, rl, fl, tl;
integer seed = 32'h09ef, n_errors = 0, n_compared = 0, cyc = 0, fb_pulses = 0;
logic [23:0] w, shreg = 24'h0, mdl [4];
tll_host host (.sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));
tll_top dut (.REF_CLK_IN(clk), .RST_IN(rst), .SERIAL_CLK_IN(sclk), .SERIAL_DATA_IN(sdata),
    .LOAD_STROBE_IN(strobe), .CHIP_ENABLE_IN(ce), .LOCK_DETECT_IN(lock), .RF_SCALED_IN(rf),
    .REF_SCALED_IN(refs), .PUMP_UP_IN(pump), .MONITOR_OUTPUT_OUT(mon), .CHARGE_PUMP_OUTPUT_OUT(cp),
    .CHARGE_PUMP_OUTPUT_OE_OUT(cp_oe), .CORE_POWERED_OUT(core), .CONTROL_LATCH_OUT(ctl),
    .REF_LATCH_OUT(rl), .FEEDBACK_LATCH_OUT(fl), .TEST_LATCH_OUT(tl), .FEEDBACK_UPDATE_OUT(fbu),
    .SHORT_WORD_OUT(shortw));
initial forever #2 clk = ~clk;
task report_and_stop;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
// Ceiling is about three times the expected run
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fbu === 1'b1) fb_pulses <= fb_pulses + 1;
    if (cyc == 20000) begin
        n_errors++;
        report_and_stop;
    end
end
function automatic logic [23:0] ctlw(input logic [2:0] m, input logic pd);
    logic [23:0] v;
    v = 24'($random(seed));
    v[21:20] = {1'b0, pd};
    v[7:5] = m;
    v[1:0] = 2'h0;
    return v;
endfunction
// ****************************************************************
// Word load with model update and full comparison
// ****************************************************************
task automatic load(input logic [23:0] v, input int n);
    int i;
    for (i = n - 1; i >= 0; i--) shreg = {shreg[22:0], v[i]};
    mdl[shreg[1:0]] = shreg;
    host.send(v, n);
    repeat (12) @(negedge clk);
    `CHK(ctl, mdl[0])
    `CHK(rl, mdl[1])
    `CHK(fl, mdl[2])
    `CHK(tl, mdl[3])
    `CHK(shortw, n < 24)
endtask
initial begin
    for (int k = 0; k < 4; k++) mdl[k] = 24'h0;
    repeat (2) @(negedge clk);
    rst = 0;
    ce = 1;
    w = 24'($random(seed));
    load({w[23:2], 2'h1}, 24);
    load(ctlw(3'h1, 1'b0), 24);
    load({w[23:2], 2'h2}, 24);
    `CHK(fb_pulses, 1)
    load({w[23:2], 2'h3}, 24);
    load({w[23:2], 2'h3}, 10);
    for (int m = 0; m < 5; m++) begin
        load(ctlw(3'(m), 1'b0), 24);
        repeat (4) begin
            {lock, rf, refs, pump} = 4'($random(seed));
            repeat (8) @(negedge clk);
            `CHK(mon, m == 1 ? lock : m == 2 ? rf : m == 3 ? refs : 1'b0)
            `CHK({cp, cp_oe}, {pump, 1'b1})
        end
    end
    // Three-state bit keeps the core up but releases the pump pin
    w = ctlw(3'h2, 1'b0);
    w[21] = 1'b1;
    load(w, 24);
    `CHK({core, cp_oe}, 2'h2)
    load(ctlw(3'h1, 1'b1), 24);
    `CHK(core, 1'b0)
    pump = 1;
    ce = 0;
    repeat (8) @(negedge clk);
    `CHK({core, cp, cp_oe, mon}, 4'h0)
    load(ctlw(3'h1, 1'b0), 24);
    `CHK(core, 1'b0)
    ce = 1;
    repeat (8) @(negedge clk);
    `CHK({core, cp, cp_oe}, 3'h7)
    `CHK(fb_pulses, 1)
    // Mid-run reset clears every latch, flag and the shift register
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    shreg = 24'h0;
    for (int k = 0; k < 4; k++) mdl[k] = 24'h0;
    `CHK({ctl, rl, fl, tl}, 96'h0)
    `CHK({core, cp, cp_oe, mon, fbu, shortw}, 6'h0)
    load({w[23:2], 2'h1}, 24);
    `CHK(fb_pulses, 1)
    report_and_stop;
end
endmodule

// File: tll_top.v
/*
 * Three-wire serial programming port of a synthesizer: shift register,
 * four latches, power-down gating of the charge pump and monitor mux.
 * Assumes the serial pins, chip enable and monitored signals are
 * asynchronous to REF_CLK_IN, which runs well above the serial clock.
 */
`timescale 1ns/1ns
`include "tll_defs.vh"

module tll_top #(
    parameter WORD_BITS = `TLL_WORD_BITS
) (
    input wire REF_CLK_IN,
    input wire RST_IN,
    input wire SERIAL_CLK_IN,
    input wire SERIAL_DATA_IN,
    input wire LOAD_STROBE_IN,
    input wire CHIP_ENABLE_IN,
    input wire LOCK_DETECT_IN,
    input wire RF_SCALED_IN,
    input wire REF_SCALED_IN,
    input wire PUMP_UP_IN,
    output wire MONITOR_OUTPUT_OUT,
    output wire CHARGE_PUMP_OUTPUT_OUT,
    output wire CHARGE_PUMP_OUTPUT_OE_OUT,
    output wire CORE_POWERED_OUT,
    output wire [WORD_BITS-1:0] CONTROL_LATCH_OUT,
    output wire [WORD_BITS-1:0] REF_LATCH_OUT,
    output wire [WORD_BITS-1:0] FEEDBACK_LATCH_OUT,
    output wire [WORD_BITS-1:0] TEST_LATCH_OUT,
    output wire FEEDBACK_UPDATE_OUT,
    output wire SHORT_WORD_OUT
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam SYNC_W = 8;
    localparam [`TLL_BITCNT_W-1:0] FULL_COUNT = WORD_BITS[`TLL_BITCNT_W-1:0];

    wire [SYNC_W-1:0] pins_async;
    wire [SYNC_W-1:0] pins_sync;
    wire sclk_s;
    wire sdata_s;
    wire load_s;
    wire ce_s;
    wire lock_s;
    wire rf_s;
    wire ref_s;
    wire pump_s;
    wire sclk_rise;
    wire load_rise;
    wire [1:0] sel;

    reg sclk_prev_q;
    reg load_prev_q;
    reg [WORD_BITS-1:0] shift_q;
    reg [WORD_BITS-1:0] shift_d;
    reg [`TLL_BITCNT_W-1:0] count_q;
    reg [`TLL_BITCNT_W-1:0] count_d;
    reg [WORD_BITS-1:0] ctl_q;
    reg [WORD_BITS-1:0] ref_q;
    reg [WORD_BITS-1:0] fb_q;
    reg [WORD_BITS-1:0] test_q;
    reg fb_update_q;
    reg short_q;
    reg short_d;
    reg powered_q;
    reg pump_oe_q;
    reg pump_q;
    reg monitor_q;
    reg monitor_d;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    // Clock and data share one stage count, so their relative timing
    // survives; the data hold time covers the sampling uncertainty.
    assign pins_async = {PUMP_UP_IN, REF_SCALED_IN, RF_SCALED_IN,
                         LOCK_DETECT_IN, CHIP_ENABLE_IN, LOAD_STROBE_IN,
                         SERIAL_DATA_IN, SERIAL_CLK_IN};

    tll_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign sdata_s = pins_sync[1];
    assign load_s = pins_sync[2];
    assign ce_s = pins_sync[3];
    assign lock_s = pins_sync[4];
    assign rf_s = pins_sync[5];
    assign ref_s = pins_sync[6];
    assign pump_s = pins_sync[7];

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            load_prev_q <= load_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign load_rise = load_s & ~load_prev_q;

    // ****************************************************************
    // Shift register
    // ****************************************************************
    // Bits enter at the bottom, so the first bit sent ends at the top
    // and the last two sent form the latch selection.
    assign sel = {shift_q[`TLL_SEL_HI], shift_q[`TLL_SEL_LO]};

    always @* begin
        shift_d = shift_q;
        count_d = count_q;
        short_d = short_q;
        if (load_rise) begin
            // A load with fewer bits than a word is flagged, not refused
            short_d = (count_q < FULL_COUNT);
            count_d = {`TLL_BITCNT_W{1'b0}};
        end else if (sclk_rise) begin
            shift_d = {shift_q[WORD_BITS-2:0], sdata_s};
            if (count_q != {`TLL_BITCNT_W{1'b1}}) begin
                count_d = count_q + 1'b1;
            end
        end
    end

    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            shift_q <= `TLL_LATCH_RESET;
            count_q <= {`TLL_BITCNT_W{1'b0}};
            short_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
            short_q <= short_d;
        end
    end

    // ****************************************************************
    // Latches
    // ****************************************************************
    // The whole word is copied, selection bits included; the test latch
    // is written like any other since the host is trusted to avoid it.
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ctl_q <= `TLL_LATCH_RESET;
            ref_q <= `TLL_LATCH_RESET;
            fb_q <= `TLL_LATCH_RESET;
            test_q <= `TLL_LATCH_RESET;
            fb_update_q <= 1'b0;
        end else begin
            fb_update_q <= 1'b0;
            if (load_rise) begin
                case (sel)
                    `TLL_SEL_CONTROL: begin
                        ctl_q <= shift_q;
                    end
                    `TLL_SEL_REF: begin
                        ref_q <= shift_q;
                    end
                    `TLL_SEL_FEEDBACK: begin
                        fb_q <= shift_q;
                        // Band selection restarts on each feedback load
                        fb_update_q <= 1'b1;
                    end
                    default: begin
                        test_q <= shift_q;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Power-down and charge pump
    // ****************************************************************
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            powered_q <= 1'b0;
            pump_oe_q <= 1'b0;
            pump_q <= 1'b0;
        end else begin
            // Chip enable is necessary but not sufficient for power
            powered_q <= ce_s & ~ctl_q[`TLL_CTL_CORE_PD_BIT];
            pump_oe_q <= ce_s & ~ctl_q[`TLL_CTL_CORE_PD_BIT]
                         & ~ctl_q[`TLL_CTL_CP_TRI_BIT];
            pump_q <= pump_s & ce_s;
        end
    end

    // ****************************************************************
    // Monitor output
    // ****************************************************************
    // The scaled clocks are sampled, so they must run well below half
    // the reference clock rate to come out cleanly.
    always @* begin
        case (ctl_q[`TLL_CTL_MON_MSB:`TLL_CTL_MON_LSB])
            `TLL_MON_LOCK: begin
                monitor_d = lock_s;
            end
            `TLL_MON_RF: begin
                monitor_d = rf_s;
            end
            `TLL_MON_REF: begin
                monitor_d = ref_s;
            end
            default: begin
                monitor_d = 1'b0;
            end
        endcase
    end

    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            monitor_q <= 1'b0;
        end else begin
            monitor_q <= monitor_d & powered_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign MONITOR_OUTPUT_OUT = monitor_q;
    assign CHARGE_PUMP_OUTPUT_OUT = pump_q;
    assign CHARGE_PUMP_OUTPUT_OE_OUT = pump_oe_q;
    assign CORE_POWERED_OUT = powered_q;
    assign CONTROL_LATCH_OUT = ctl_q;
    assign REF_LATCH_OUT = ref_q;
    assign FEEDBACK_LATCH_OUT = fb_q;
    assign TEST_LATCH_OUT = test_q;
    assign FEEDBACK_UPDATE_OUT = fb_update_q;
    assign SHORT_WORD_OUT = short_q;
endmodule
